// *** rtl/pesc_params.svh ***
// Offsets, field positions and reset values of the event select block
`ifndef PESC_PARAMS_SVH
`define PESC_PARAMS_SVH
// Register indexes; byte address is four times the index
`define PESC_IDX_CTR0   12'h0c1
`define PESC_IDX_CTR1   12'h0c2
`define PESC_IDX_SEL0   12'h186
`define PESC_IDX_SEL1   12'h187
`define PESC_IDX_STAT   12'h190
`define PESC_IDX_MASK   12'h191
`define PESC_IDX_LIVE   12'h192
// Event select field positions
`define PESC_CODE_LSB   0
`define PESC_CODE_MSB   7
`define PESC_QUAL_LSB   8
`define PESC_QUAL_MSB   15
`define PESC_USER_BIT   16
`define PESC_KERN_BIT   17
`define PESC_OCC_BIT    18
`define PESC_PIN_BIT    19
`define PESC_INT_BIT    20
`define PESC_GEN_BIT    22
`define PESC_NEG_BIT    23
`define PESC_THR_LSB    24
`define PESC_THR_MSB    31
// Widths and reset values
`define PESC_CNT_W      32
`define PESC_SEL_RST    32'h0000_0000
`define PESC_CTR_RST    32'h0000_0000
`define PESC_IRQ_RST    2'h0
`endif

// *** rtl/pesc_pkg.sv ***
// Types shared by the event select block
package pesc_pkg;
    typedef logic [31:0] pesc_word_type;
    typedef logic [7:0]  pesc_byte_type;
    typedef enum logic { PESC_DURATION, PESC_OCCURRENCE } pesc_mode_type;
endpackage : pesc_pkg

// *** rtl/pesc_cnt_if.sv ***
// Carrier between the register file and one event counter
`timescale 1ns/1ps
`include "pesc_params.svh"
interface pesc_cnt_if;
    pesc_pkg::pesc_word_type  cfg;
    logic                     glob_en;
    logic [1:0]               priv;
    pesc_pkg::pesc_byte_type  evt_cnt;
    logic                     wr_en;
    logic [`PESC_CNT_W-1:0]   wr_data;
    logic [`PESC_CNT_W-1:0]   count;
    logic                     ovf;
    logic                     running;
    modport ctl (output cfg, glob_en, priv, evt_cnt, wr_en, wr_data,
                 input count, ovf, running);
    modport cnt (input cfg, glob_en, priv, evt_cnt, wr_en, wr_data,
                 output count, ovf, running);
endinterface : pesc_cnt_if

// *** rtl/pesc_counter.sv ***
// One event counter with privilege filter, mode and threshold
`timescale 1ns/1ps
`include "pesc_params.svh"
module pesc_counter
(
    input wire logic   clk,
    input wire logic   srst,
    pesc_cnt_if.cnt    cif
);
    logic [`PESC_CNT_W-1:0] count_reg;
    logic [`PESC_CNT_W-1:0] count_next;
    logic                   ovf_reg;
    logic                   ovf_next;
    logic                   priv_ok;
    logic                   run;
    logic                   pass;
    pesc_pkg::pesc_byte_type thr;
    pesc_pkg::pesc_byte_type inc;
    pesc_pkg::pesc_mode_type mode;
    logic [`PESC_CNT_W:0]   sum;

    // Qualify, threshold and accumulate one cycle of events
    always_comb
    begin
        thr     = cif.cfg[`PESC_THR_MSB:`PESC_THR_LSB];
        mode    = cif.cfg[`PESC_OCC_BIT] ? pesc_pkg::PESC_OCCURRENCE
                                         : pesc_pkg::PESC_DURATION;
        priv_ok = (cif.priv == 2'h0) ? cif.cfg[`PESC_KERN_BIT]
                                     : cif.cfg[`PESC_USER_BIT];
        run     = cif.glob_en & priv_ok;
        pass    = (cif.evt_cnt >= thr) ^ cif.cfg[`PESC_NEG_BIT];
        if (thr != 8'h00)
            inc = {7'h00, pass};
        else if (mode == pesc_pkg::PESC_OCCURRENCE)
            inc = cif.evt_cnt;
        else
            inc = {7'h00, cif.evt_cnt != 8'h00};
        sum = {1'b0, count_reg} + {{(`PESC_CNT_W - 7){1'b0}}, inc};
        count_next = count_reg;
        ovf_next   = 1'b0;
        if (cif.wr_en)
            count_next = cif.wr_data;
        else if (run)
        begin
            count_next = sum[`PESC_CNT_W-1:0];
            ovf_next   = sum[`PESC_CNT_W];
        end
    end

    // Counter value
    always_ff @(posedge clk)
    begin
        if (srst)
            count_reg <= `PESC_CTR_RST;
        else
            count_reg <= count_next;
    end

    // Wrap pulse, high with the wrapped value
    always_ff @(posedge clk)
    begin
        if (srst)
            ovf_reg <= 1'b0;
        else
            ovf_reg <= ovf_next;
    end

    assign cif.count   = count_reg;
    assign cif.ovf     = ovf_reg;
    assign cif.running = run;

    chk_halt_hold: assert property (
        @(posedge clk) disable iff (srst)
        (!cif.glob_en && !cif.wr_en) |=> $stable(count_reg))
        else $error("Counter moved while halted");

    chk_wrap_pulse: assert property (
        @(posedge clk) disable iff (srst)
        ovf_reg |-> (count_reg < 32'h0000_0100) && $past(count_reg) > 32'hffff_ff00)
        else $error("Overflow pulse without a wrap");

    chk_thr_step: assert property (
        @(posedge clk) disable iff (srst)
        (run && !cif.wr_en && thr != 8'h00 && !ovf_next)
        |=> count_reg - $past(count_reg) <= 32'h0000_0001)
        else $error("Threshold mode added more than one");
endmodule : pesc_counter

// *** rtl/pesc_top.sv ***
// Event select registers and two event counters behind classic Wishbone
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "pesc_params.svh"

// How it works
// - Bits 7:0 of each select register give the event code the counter tallies.
// - Bits 15:8 qualify the event; zero there enables every option of it.
// - Bit 16 allows counting at levels 1 to 3 and bit 17 at level 0.
// - Bit 18 high counts occurrences, low counts cycles while the event holds.
// - Bit 19 sends the counter's overflow to the overflow pin.
// - Bit 20 passes overflow to the interrupt status, and on to irq where its mask bit is set; low raises nothing.
// - Bit 22 of the first select register lets both counters run or halts them.
// - Bit 23 inverts the threshold comparison before the count decision.
// - Bits 31:24 hold an 8-bit threshold applied to each cycle's event count.
// - A second select register serves the second counter with the same layout.
module pesc_top
(
    input  wire logic          clk,
    input  wire logic          srst,
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [15:0]   wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic      [31:0]   wb_dat_o,
    output logic               wb_ack_o,
    input  wire logic [1:0]    priv_level,
    input  wire logic [7:0]    evt0_count,
    input  wire logic [7:0]    evt1_count,
    output logic      [7:0]    evt0_code,
    output logic      [7:0]    evt0_qual,
    output logic      [7:0]    evt1_code,
    output logic      [7:0]    evt1_qual,
    output logic               ovf_pin,
    output logic               irq
);
    pesc_pkg::pesc_word_type  sel_reg [2];
    pesc_pkg::pesc_word_type  dat_reg;
    pesc_pkg::pesc_word_type  dat_next;
    pesc_pkg::pesc_word_type  byte_mask;
    logic [1:0]               stat_reg;
    logic [1:0]               stat_next;
    logic [1:0]               mask_reg;
    logic                     ack_reg;
    logic                     pin_reg;
    logic                     access;
    logic                     wr_stb;
    logic                     hit_top;
    logic [11:0]              idx;
    logic [1:0]               ovf_vec;
    logic [1:0]               run_vec;
    logic [1:0]               sel_wr;
    logic [1:0]               ctr_wr;
    logic [`PESC_CNT_W-1:0]   ctr_val [2];
    logic [7:0]               evt_in [2];

    // Bus decode: one request is served per ack, ack drops a cycle later
    assign access  = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr_stb  = access & wb_we_i;
    assign idx     = wb_adr_i[13:2];
    assign hit_top = (wb_adr_i[15:14] == 2'h0);
    assign evt_in[0] = evt0_count;
    assign evt_in[1] = evt1_count;

    // Byte lanes to a bit mask
    always_comb
    begin
        byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                     {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    end

    // Write strobes per register
    always_comb
    begin
        sel_wr[0] = wr_stb & hit_top & (idx == `PESC_IDX_SEL0);
        sel_wr[1] = wr_stb & hit_top & (idx == `PESC_IDX_SEL1);
        ctr_wr[0] = wr_stb & hit_top & (idx == `PESC_IDX_CTR0);
        ctr_wr[1] = wr_stb & hit_top & (idx == `PESC_IDX_CTR1);
    end

    // One counter per select register
    genvar g;
    for (g = 0; g < 2; g++)
    begin : g_ctr
        pesc_cnt_if cif ();
        assign cif.cfg     = sel_reg[g];
        assign cif.glob_en = sel_reg[0][`PESC_GEN_BIT];
        assign cif.priv    = priv_level;
        assign cif.evt_cnt = evt_in[g];
        assign cif.wr_en   = ctr_wr[g];
        assign cif.wr_data = (cif.count & ~byte_mask) | (wb_dat_i & byte_mask);
        assign ctr_val[g]  = cif.count;
        assign ovf_vec[g]  = cif.ovf;
        assign run_vec[g]  = cif.running;
        pesc_counter u_ctr
        (
            .clk  (clk),
            .srst (srst),
            .cif  (cif)
        );

        // Select register with byte lane writes
        always_ff @(posedge clk)
        begin
            if (srst)
                sel_reg[g] <= `PESC_SEL_RST;
            else if (sel_wr[g])
                sel_reg[g] <= (sel_reg[g] & ~byte_mask) | (wb_dat_i & byte_mask);
        end
    end

    // Event code and qualifier go to the event sources
    assign evt0_code = sel_reg[0][`PESC_CODE_MSB:`PESC_CODE_LSB];
    assign evt1_code = sel_reg[1][`PESC_CODE_MSB:`PESC_CODE_LSB];
    assign evt0_qual = sel_reg[0][`PESC_QUAL_MSB:`PESC_QUAL_LSB];
    assign evt1_qual = sel_reg[1][`PESC_QUAL_MSB:`PESC_QUAL_LSB];

    // Sticky interrupt status, set wins over the write-one clear
    always_comb
    begin
        stat_next = stat_reg;
        if (wr_stb && hit_top && idx == `PESC_IDX_STAT && wb_sel_i[0])
            stat_next = stat_reg & ~wb_dat_i[1:0];
        stat_next[0] = stat_next[0] | (ovf_vec[0] & sel_reg[0][`PESC_INT_BIT]);
        stat_next[1] = stat_next[1] | (ovf_vec[1] & sel_reg[1][`PESC_INT_BIT]);
    end

    // Status register
    always_ff @(posedge clk)
    begin
        if (srst)
            stat_reg <= `PESC_IRQ_RST;
        else
            stat_reg <= stat_next;
    end

    // Interrupt mask register
    always_ff @(posedge clk)
    begin
        if (srst)
            mask_reg <= `PESC_IRQ_RST;
        else if (wr_stb && hit_top && idx == `PESC_IDX_MASK && wb_sel_i[0])
            mask_reg <= wb_dat_i[1:0];
    end

    // Level request to the interrupt controller
    assign irq = |(stat_reg & mask_reg);

    // Overflow pin pulses one cycle after a wrap
    always_ff @(posedge clk)
    begin
        if (srst)
            pin_reg <= 1'b0;
        else
            pin_reg <= (ovf_vec[0] & sel_reg[0][`PESC_PIN_BIT])
                     | (ovf_vec[1] & sel_reg[1][`PESC_PIN_BIT]);
    end
    assign ovf_pin = pin_reg;

    // Read multiplexer, unmapped addresses read as zero
    always_comb
    begin
        dat_next = 32'h0000_0000;
        if (hit_top)
        begin
            case (idx)
                `PESC_IDX_SEL0: dat_next = sel_reg[0];
                `PESC_IDX_SEL1: dat_next = sel_reg[1];
                `PESC_IDX_CTR0: dat_next = ctr_val[0];
                `PESC_IDX_CTR1: dat_next = ctr_val[1];
                `PESC_IDX_STAT: dat_next = {30'h0000_0000, stat_reg};
                `PESC_IDX_MASK: dat_next = {30'h0000_0000, mask_reg};
                `PESC_IDX_LIVE: dat_next = {28'h000_0000, priv_level, run_vec};
                default:        dat_next = 32'h0000_0000;
            endcase
        end
    end

    // Read data register
    always_ff @(posedge clk)
    begin
        if (srst)
            dat_reg <= 32'h0000_0000;
        else if (access && !wb_we_i)
            dat_reg <= dat_next;
    end

    // Acknowledge, one cycle after the request
    always_ff @(posedge clk)
    begin
        if (srst)
            ack_reg <= 1'b0;
        else
            ack_reg <= access;
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    chk_ack_single: assert property (
        @(posedge clk) disable iff (srst)
        wb_ack_o |=> !wb_ack_o)
        else $error("Ack held for more than one cycle");

    chk_code_write: assert property (
        @(posedge clk) disable iff (srst)
        (sel_wr[0] && wb_sel_i[0]) |=> evt0_code == $past(wb_dat_i[7:0]))
        else $error("Event code not taken from write");

    chk_pin_cause: assert property (
        @(posedge clk) disable iff (srst)
        ovf_pin |-> $past((ovf_vec[0] && sel_reg[0][`PESC_PIN_BIT])
                       || (ovf_vec[1] && sel_reg[1][`PESC_PIN_BIT])))
        else $error("Overflow pin without enabled overflow");

    chk_int_set: assert property (
        @(posedge clk) disable iff (srst)
        (ovf_vec[0] && sel_reg[0][`PESC_INT_BIT]) |=> stat_reg[0])
        else $error("Enabled overflow did not set status");

    chk_int_off: assert property (
        @(posedge clk) disable iff (srst)
        (!stat_reg[1] && !(ovf_vec[1] && sel_reg[1][`PESC_INT_BIT])) |=> !stat_reg[1])
        else $error("Status set without enabled overflow");
endmodule : pesc_top

// *** test/pesc_top_tb_top.sv ***
// Self-checking bench for the event select block over classic Wishbone
`timescale 1ns/1ps
`include "pesc_params.svh"
module pesc_top_tb_top;
    localparam logic [15:0] A_SEL0 = {2'h0, `PESC_IDX_SEL0, 2'h0};
    localparam logic [15:0] A_SEL1 = {2'h0, `PESC_IDX_SEL1, 2'h0};
    localparam logic [15:0] A_CTR0 = {2'h0, `PESC_IDX_CTR0, 2'h0};
    localparam logic [15:0] A_CTR1 = {2'h0, `PESC_IDX_CTR1, 2'h0};
    localparam logic [15:0] A_STAT = {2'h0, `PESC_IDX_STAT, 2'h0};
    localparam logic [15:0] A_MASK = {2'h0, `PESC_IDX_MASK, 2'h0};
    localparam logic [15:0] A_LIVE = {2'h0, `PESC_IDX_LIVE, 2'h0};
    localparam logic [31:0] F_USR  = 32'h0001_0000;
    localparam logic [31:0] F_KRN  = 32'h0002_0000;
    localparam logic [31:0] F_OCC  = 32'h0004_0000;
    localparam logic [31:0] F_PIN  = 32'h0008_0000;
    localparam logic [31:0] F_INT  = 32'h0010_0000;
    localparam logic [31:0] F_EN   = 32'h0040_0000;
    localparam logic [31:0] F_NEG  = 32'h0080_0000;
    localparam logic [31:0] F_THR3 = 32'h0300_0000;
    logic        clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ovf_pin, irq;
    logic [15:0] wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [1:0]  priv_level;
    logic [7:0]  evt0_count, evt1_count, evt0_code, evt0_qual, evt1_code, evt1_qual;
    int          miscompares, compares, ovf_seen;

    pesc_top pesc_top_inst (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .priv_level(priv_level),
        .evt0_count(evt0_count), .evt1_count(evt1_count), .evt0_code(evt0_code),
        .evt0_qual(evt0_qual), .evt1_code(evt1_code), .evt1_qual(evt1_qual),
        .ovf_pin(ovf_pin), .irq(irq));

    // Clock generation, 10 ns period
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Counts cycles with the overflow pin high
    always @(posedge clk)
        if (ovf_pin === 1'b1) ovf_seen++;

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One classic Wishbone cycle; holds the request until ack is sampled
    task automatic wb(input logic we, input logic [15:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= 4'hf;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) miscompares++;
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask : wb

    task automatic rdc(input string what, input logic [15:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0000_0000);
        chk(what, rd, exp);
    endtask : rdc

    // Drives both event counts for n cycles, then returns them to zero
    task automatic ev(input logic [7:0] e0, input logic [7:0] e1, input int n);
        @(posedge clk);
        evt0_count <= e0;
        evt1_count <= e1;
        repeat (n) @(posedge clk);
        evt0_count <= 8'h00;
        evt1_count <= 8'h00;
    endtask : ev

    // Programs both selects and clears both counters
    task automatic setup(input logic [31:0] s0, input logic [31:0] s1);
        wb(1'b1, A_SEL0, s0);
        wb(1'b1, A_SEL1, s1);
        wb(1'b1, A_CTR0, 32'h0000_0000);
        wb(1'b1, A_CTR1, 32'h0000_0000);
    endtask : setup

    task automatic end_of_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test

    // Watchdog against a hung handshake
    initial
    begin
        repeat (5000) @(posedge clk);
        miscompares++;
        end_of_test();
    end

    // Main test sequence
    initial
    begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {priv_level, evt0_count, evt1_count} = '0;
        srst = 1'b1;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        rdc("sel0 reset", A_SEL0, `PESC_SEL_RST);
        rdc("ctr1 reset", A_CTR1, `PESC_CTR_RST);
        // Event code and qualifier fields
        wb(1'b1, A_SEL0, 32'h0000_a53c);
        wb(1'b1, A_SEL1, 32'h0000_5ac3);
        chk("code0", {24'h0, evt0_code}, 32'h0000_003c);
        chk("qual0", {24'h0, evt0_qual}, 32'h0000_00a5);
        chk("code1", {24'h0, evt1_code}, 32'h0000_00c3);
        chk("qual1", {24'h0, evt1_qual}, 32'h0000_005a);
        rdc("sel0 back", A_SEL0, 32'h0000_a53c);
        // Global enable clear halts both
        setup(F_KRN | F_OCC, F_KRN | F_OCC);
        ev(8'h02, 8'h02, 4);
        rdc("halted ctr0", A_CTR0, 32'h0000_0000);
        rdc("halted ctr1", A_CTR1, 32'h0000_0000);
        // Occurrence mode adds raw count, enable taken from first select only
        setup(F_EN | F_KRN | F_OCC, F_KRN | F_OCC);
        ev(8'h03, 8'h02, 4);
        rdc("occ ctr0", A_CTR0, 32'h0000_000c);
        rdc("occ ctr1", A_CTR1, 32'h0000_0008);
        // Privilege filter at level 3, then level 0
        setup(F_EN | F_KRN | F_OCC, F_USR | F_OCC);
        priv_level <= 2'h3;
        ev(8'h01, 8'h01, 5);
        rdc("user ctr0", A_CTR0, 32'h0000_0000);
        rdc("user ctr1", A_CTR1, 32'h0000_0005);
        priv_level <= 2'h0;
        ev(8'h01, 8'h01, 5);
        rdc("kern ctr0", A_CTR0, 32'h0000_0005);
        rdc("kern ctr1", A_CTR1, 32'h0000_0005);
        // Duration mode counts cycles
        setup(F_EN | F_KRN, F_KRN);
        ev(8'h05, 8'h00, 4);
        rdc("dur ctr0", A_CTR0, 32'h0000_0004);
        // Threshold three, plain and inverted; second counter runs only at levels 1 to 3
        setup(F_EN | F_KRN | F_USR | F_OCC | F_THR3, F_USR | F_OCC | F_NEG | F_THR3);
        priv_level <= 2'h3;
        ev(8'h04, 8'h04, 2);
        ev(8'h02, 8'h02, 3);
        priv_level <= 2'h0;
        rdc("thr ctr0", A_CTR0, 32'h0000_0002);
        // Inverted counts the three low cycles plus the idle edge ahead of each burst
        rdc("inv ctr1", A_CTR1, 32'h0000_0005);
        // Wrap with pin and interrupt routing on
        setup(F_EN | F_KRN | F_OCC | F_PIN | F_INT, 32'h0000_0000);
        wb(1'b1, A_MASK, 32'h0000_0001);
        wb(1'b1, A_CTR0, 32'hffff_ffff);
        ovf_seen = 0;
        ev(8'h01, 8'h00, 1);
        repeat (4) @(posedge clk);
        chk("ovf pulses", ovf_seen, 32'h0000_0001);
        rdc("wrap ctr0", A_CTR0, 32'h0000_0000);
        rdc("status", A_STAT, 32'h0000_0001);
        @(negedge clk);
        chk("irq set", {31'h0, irq}, 32'h0000_0001);
        wb(1'b1, A_STAT, 32'h0000_0001);
        @(negedge clk);
        chk("irq clear", {31'h0, irq}, 32'h0000_0000);
        // Wrap with routing off raises nothing
        wb(1'b1, A_SEL0, F_EN | F_KRN | F_OCC);
        wb(1'b1, A_CTR0, 32'hffff_ffff);
        ovf_seen = 0;
        ev(8'h01, 8'h00, 1);
        repeat (4) @(posedge clk);
        chk("no pin", ovf_seen, 32'h0000_0000);
        chk("no irq", {31'h0, irq}, 32'h0000_0000);
        rdc("live", A_LIVE, 32'h0000_0001);
        rdc("unmapped", 16'h0100, 32'h0000_0000);
        end_of_test();
    end
endmodule : pesc_top_tb_top
